//--- src/crf_framer.sv
// Capture record framer plus its output FIFO.
// Assumes a capture source that gives a descriptor with each packet and
// a consumer that writes the 32-bit word stream into host memory.
//
// Summary of operation
// - Type field carries 5,6,7,8,9 or 12; others map to raw channel 8.
// - Exactly one record is emitted per captured packet.
// - Output holds only back-to-back records, no stream header.
// - Timestamp is written least significant byte first.
// - Type, flags, lengths and loss counter are big-endian.
// - Payload bytes keep line order, never swapped.
// - Header: two stamp words, type/flags/rlen word, loss/wlen word.
// - Record length includes 16 header bytes; body is rlen minus 16.
// - Header fields sit at the same place for all types.
// - Timestamp is the 64-bit descriptor stamp, or the card_time arrival time when that stamp is zero.
// - Flags bits 1-0 give interface, bit 2 marks varying lengths.
`timescale 1ns/100ps
`include "crf_map.svh"

// ---------------------------------------------------------------
// Synchronous FIFO
// ---------------------------------------------------------------
module crf_fifo #(
  parameter int WIDTH = 33,
  parameter int DEPTH = `CRF_FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic full;
  logic empty;

  assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign empty = (wr_ptr == rd_ptr);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge core_clk) begin
    if (in_valid && !full) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wr_ptr <= '0;
    end else if (in_valid && !full) begin
      wr_ptr <= wr_ptr + {{AW{1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rd_ptr <= '0;
    end else if (out_ready && !empty) begin
      rd_ptr <= rd_ptr + {{AW{1'b0}}, 1'b1};
    end
  end
endmodule : crf_fifo

// ---------------------------------------------------------------
// Framer top
// ---------------------------------------------------------------
module crf_framer
  import crf_pkg::*;
#(
  parameter int FIFO_DEPTH = `CRF_FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [63:0] card_time,
  input wire crf_desc_t pkt_desc,
  input wire crf_beat_t pkt_beat,
  input wire logic pkt_valid,
  output logic pkt_ready,
  output logic [31:0] rec_data,
  output logic rec_last,
  output logic rec_valid,
  input wire logic rec_ready,
  output logic [31:0] rec_count
);
  crf_state_t state;
  crf_desc_t desc;
  logic [63:0] arrival;
  logic [2:0] hdr_idx;
  logic [15:0] body_left;
  logic [31:0] word;
  logic word_last;
  logic word_valid;
  logic fifo_ready;
  logic take;
  logic [7:0] rtype;
  logic [15:0] rlen;
  logic [15:0] body_len;

  // ---------------------------------------------------------------
  // Header field formatting
  // ---------------------------------------------------------------
  // unknown codes map to raw channel type 8
  always_comb begin
    case (desc.rtype)
      `CRF_MULTICHANNEL_HDLC_TYPE, `CRF_MULTICHANNEL_RAW_TYPE, `CRF_TYPE_MC_CELL,
      `CRF_MULTICHANNEL_RAW_TYPE_CHAN, `CRF_MULTICHANNEL_AAL5_TYPE, `CRF_MULTICHANNEL_AAL2_TYPE: rtype = desc.rtype;
      default: rtype = `CRF_MULTICHANNEL_RAW_TYPE_CHAN;
    endcase
  end

  // Body is padded to whole words so rlen stays word aligned for the reader
  assign body_len = (desc.caplen + 16'h0003) & 16'hfffc;
  assign rlen = body_len + `CRF_HDR_BYTES;

  function automatic logic [31:0] crf_swap(input logic [31:0] v);
    crf_swap = {v[7:0], v[15:8], v[23:16], v[31:24]};
  endfunction : crf_swap

  // Header words, with byte 0 of the record stream in bits 31:24
  always_comb begin
    word = '0;
    word_last = 1'b0;
    word_valid = 1'b0;
    take = 1'b0;
    case (state)
      crf_hdr: begin
        word_valid = 1'b1;
        case (hdr_idx)
          3'h0: word = crf_swap(arrival[31:0]);
          3'h1: word = crf_swap(arrival[63:32]);
          3'h2: word = {rtype, 5'h00, desc.varlen, desc.iface, rlen};
          default: word = {desc.loss, desc.wlen};
        endcase
        word_last = (body_left == 16'h0000) && (hdr_idx == 3'h3);
      end
      crf_body: begin
        // bytes kept in line order; absent lanes zeroed
        for (int i = 0; i < 4; i++) begin
          word[31-8*i -: 8] = pkt_beat.keep[3-i] ? pkt_beat.data[31-8*i -: 8] : 8'h00;
        end
        word_valid = pkt_valid;
        word_last = (body_left == 16'h0004);
        take = pkt_valid && fifo_ready;
      end
      crf_pad: begin
        word_valid = 1'b1;
        word_last = (body_left == 16'h0004);
      end
      default: begin
        word_valid = 1'b0;
      end
    endcase
  end

  // Capture side stalls while the FIFO is full
  assign pkt_ready = (state == crf_idle) ? 1'b0 : take;

  // ---------------------------------------------------------------
  // Record sequencer
  // ---------------------------------------------------------------
  // one record per packet
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state <= crf_idle;
      hdr_idx <= 3'h0;
      body_left <= 16'h0000;
    end else begin
      case (state)
        crf_idle: begin
          if (pkt_valid) begin
            state <= crf_hdr;
            hdr_idx <= 3'h0;
            body_left <= (pkt_desc.caplen + 16'h0003) & 16'hfffc;
          end
        end
        crf_hdr: begin
          if (fifo_ready) begin
            hdr_idx <= hdr_idx + 3'h1;
            if (hdr_idx == `CRF_HDR_WORDS - 3'h1) begin
              state <= (body_left == 16'h0000) ? crf_idle : crf_body;
            end
          end
        end
        crf_body: begin
          if (take) begin
            body_left <= body_left - 16'h0004;
            if (body_left == 16'h0004) begin
              state <= crf_idle;
            end else if (pkt_beat.last) begin
              // Source ended short of caplen: pad so rlen stays true
              state <= crf_pad;
            end
          end
        end
        crf_pad: begin
          if (fifo_ready) begin
            body_left <= body_left - 16'h0004;
            if (body_left == 16'h0004) begin
              state <= crf_idle;
            end
          end
        end
        default: state <= crf_idle;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      desc <= '0;
      arrival <= 64'h0000000000000000;
    end else if (state == crf_idle && pkt_valid) begin
      desc <= pkt_desc;
      arrival <= (pkt_desc.stamp != 64'h0000000000000000) ? pkt_desc.stamp : card_time;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rec_count <= 32'h00000000;
    end else if (word_valid && fifo_ready && word_last) begin
      rec_count <= rec_count + 32'h00000001;
    end
  end

  crf_fifo #(
    .WIDTH(33),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .in_data({word_last, word}),
    .in_valid(word_valid),
    .in_ready(fifo_ready),
    .out_data({rec_last, rec_data}),
    .out_valid(rec_valid),
    .out_ready(rec_ready)
  );
endmodule : crf_framer

//--- src/crf_map.svh
// Offsets, field positions and codes of the capture record header.
// Assumes inclusion by the package and by the framer only.
`ifndef CRF_MAP_SVH
`define CRF_MAP_SVH
`define CRF_HDR_BYTES 16'h0010
`define CRF_HDR_WORDS 3'h4
`define CRF_MULTICHANNEL_HDLC_TYPE 8'h05
`define CRF_MULTICHANNEL_RAW_TYPE 8'h06
`define CRF_TYPE_MC_CELL 8'h07
`define CRF_MULTICHANNEL_RAW_TYPE_CHAN 8'h08
`define CRF_MULTICHANNEL_AAL5_TYPE 8'h09
`define CRF_MULTICHANNEL_AAL2_TYPE 8'h0c
`define CRF_FLAG_IFACE_LSB 0
`define CRF_FLAG_VARLEN_BIT 2
`define CRF_FIFO_DEPTH 32
`endif

//--- src/crf_pkg.sv
// Types shared by the capture record framer.
// Assumes crf_map.svh is on the include path.
`include "crf_map.svh"
package crf_pkg;
  typedef enum logic [2:0] {
    crf_idle = 3'b000,
    crf_hdr = 3'b001,
    crf_body = 3'b010,
    crf_pad = 3'b011
  } crf_state_t;

  // One beat of packet data from the capture side
  typedef struct packed {
    logic [31:0] data;
    logic [3:0] keep;
    logic last;
  } crf_beat_t;

  // Per-packet descriptor given with the first beat
  typedef struct packed {
    logic [63:0] stamp;
    logic [7:0] rtype;
    logic [1:0] iface;
    logic varlen;
    logic [15:0] loss;
    logic [15:0] wlen;
    logic [15:0] caplen;
  } crf_desc_t;
endpackage : crf_pkg

//--- test/crf_framer_props.sv
// Checker for the capture record framer ports.
// Assumes it is bound to crf_framer.
`timescale 1ns/100ps
module crf_framer_props
  import crf_pkg::*;
#(
  parameter int FIFO_DEPTH = 32
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [63:0] card_time,
  input wire crf_desc_t pkt_desc,
  input wire crf_beat_t pkt_beat,
  input wire logic pkt_valid,
  input wire logic pkt_ready,
  input wire logic [31:0] rec_data,
  input wire logic rec_last,
  input wire logic rec_valid,
  input wire logic rec_ready,
  input wire logic [31:0] rec_count
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ----
  // Word index within a record
  // ----
  logic [15:0] widx;
  logic [15:0] rlen;
  wire logic take = rec_valid && rec_ready;
  always_ff @(posedge core_clk) begin
    if (!rst_n || (take && rec_last)) widx <= 16'h0000;
    else if (take) widx <= widx + 16'h0001;
  end
  always_ff @(posedge core_clk) begin
    if (take && widx == 16'h0002) rlen <= rec_data[15:0];
  end
  chk_hold_word:
  assert property (rec_valid && !rec_ready |=> rec_valid && $stable({rec_last, rec_data}))
    else $error("record word changed while stalled");
  chk_type_code:
  assert property (take && widx == 16'h0002 |->
    rec_data[31:24] inside {8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0c})
    else $error("bad record type");
  chk_hdr_fields:
  assert property (take && widx == 16'h0002 |->
    rec_data[23:19] == 5'h00 && rec_data[15:0] >= 16'h0010 && rec_data[1:0] == 2'h0)
    else $error("bad flags or length");
  chk_rlen_match:
  assert property (take && rec_last |-> {widx[13:0], 2'h0} + 16'h0004 == rlen)
    else $error("record size differs from length field");
  chk_no_early_last:
  assert property (take && widx < 16'h0003 |-> !rec_last)
    else $error("record ended inside header");
  chk_count_step:
  assert property (1 |=> rec_count == $past(rec_count) || rec_count == $past(rec_count) + 1)
    else $error("record count jumped");
  chk_idle_ready:
  assert property ($rose(pkt_valid) |-> !pkt_ready [*5])
    else $error("beat taken during header");
  chk_first_word:
  assert property ($rose(pkt_valid) |-> ##[1:3] rec_valid)
    else $error("no header word after start");
endmodule : crf_framer_props
bind crf_framer crf_framer_props #(.FIFO_DEPTH(FIFO_DEPTH)) i_crf_framer_props (
  .core_clk(core_clk), .rst_n(rst_n), .card_time(card_time), .pkt_desc(pkt_desc),
  .pkt_beat(pkt_beat), .pkt_valid(pkt_valid), .pkt_ready(pkt_ready), .rec_data(rec_data),
  .rec_last(rec_last), .rec_valid(rec_valid), .rec_ready(rec_ready), .rec_count(rec_count));

//--- test/crf_host_model.sv
// Host memory model that stores record words.
// Assumes the framer's valid/ready output side.
`timescale 1ns/100ps
module crf_host_model (
  input wire logic core_clk,
  input wire logic hold,
  input wire logic rec_valid,
  input wire logic [31:0] rec_data,
  output logic rec_ready
);
  logic [31:0] mem [0:1023];
  logic [9:0] wr_ptr = 10'h000;
  initial rec_ready = 1'b0;
  // Random stalls act as a slow host
  always @(posedge core_clk) begin
    if (rec_valid && rec_ready) begin
      mem[wr_ptr] <= rec_data;
      wr_ptr <= wr_ptr + 10'h001;
    end
    rec_ready <= #1 !hold && ($urandom % 4 != 0);
  end
endmodule : crf_host_model

//--- test/testbench.sv
// Self-checking bench for the capture record framer.
// Assumes package, framer, host model and checker are compiled first.
`timescale 1ns/100ps
module testbench;
  import crf_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [63:0] card_time = 64'h0;
  crf_desc_t pkt_desc = '0;
  crf_beat_t pkt_beat = '0;
  logic pkt_valid = 1'b0;
  logic hold = 1'b0;
  logic pkt_ready, rec_last, rec_valid, rec_ready;
  logic [31:0] rec_data, rec_count;
  logic [32:0] expq [$];
  logic [7:0] codes [7] = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0c, 8'h33};
  int fails = 0;
  int samples_checked = 0;
  int npkt = 0;
  crf_framer i_crf_framer (.core_clk(core_clk), .rst_n(rst_n), .card_time(card_time),
    .pkt_desc(pkt_desc), .pkt_beat(pkt_beat), .pkt_valid(pkt_valid), .pkt_ready(pkt_ready),
    .rec_data(rec_data), .rec_last(rec_last), .rec_valid(rec_valid), .rec_ready(rec_ready),
    .rec_count(rec_count));
  crf_host_model i_crf_host_model (.core_clk(core_clk), .hold(hold), .rec_valid(rec_valid),
    .rec_data(rec_data), .rec_ready(rec_ready));
  initial forever #2 core_clk = ~core_clk;
  task automatic end_of_test;
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  task automatic flag(input string msg);
    fails++;
    $display("unexpected %0t %s", $time, msg);
  endtask : flag
  // Handshake settles before the edge, so look at the falling edge
  always @(negedge core_clk) begin
    if (rst_n && rec_valid && rec_ready) begin
      samples_checked++;
      if (expq.size() == 0 || expq[0] !== {rec_last, rec_data}) flag("word");
      if (expq.size() != 0) void'(expq.pop_front());
    end
  end
  task automatic wait_ready;
    int n;
    n = 0;
    @(negedge core_clk);
    while (!pkt_ready && n < 500) begin
      n++;
      @(negedge core_clk);
    end
    if (!pkt_ready) begin
      flag("beat timeout");
      end_of_test();
    end
    @(posedge core_clk);
    #1;
  endtask : wait_ready
  // A nonzero cut ends the source that many words early; the framer pads with zeros
  task automatic send_pkt(input logic [7:0] code, input int caplen, input int cut);
    logic [63:0] s;
    logic [31:0] w;
    logic [3:0] kp;
    int nw;
    nw = (caplen + 3) / 4;
    pkt_desc = '{{$urandom, $urandom}, code, 2'($urandom), 1'($urandom), 16'($urandom),
      16'($urandom), 16'(caplen)};
    card_time = {$urandom, $urandom};
    if (npkt == 3) pkt_desc.stamp = 64'h0;
    s = (pkt_desc.stamp == 64'h0) ? card_time : pkt_desc.stamp;
    s = {<<8{s}};
    expq.push_back({1'b0, s[63:32]});
    expq.push_back({1'b0, s[31:0]});
    expq.push_back({1'b0, (code == 8'h33) ? 8'h08 : code, 5'h00, pkt_desc.varlen,
      pkt_desc.iface, 16'(nw * 4 + 16)});
    expq.push_back({nw == 0, pkt_desc.loss, pkt_desc.wlen});
    pkt_valid = 1'b1;
    for (int i = 0; i < nw; i++) begin
      w = $urandom;
      kp = 4'(4'hf << (4 - ((caplen - 4 * i > 4) ? 4 : caplen - 4 * i)));
      if (i < nw - cut) begin
        expq.push_back({i == nw - 1, w & {{8{kp[3]}}, {8{kp[2]}}, {8{kp[1]}}, {8{kp[0]}}}});
        pkt_beat = '{w, kp, i == nw - cut - 1};
        wait_ready();
      end else begin
        expq.push_back({i == nw - 1, 32'h00000000});
      end
    end
    pkt_valid = 1'b0;
    npkt++;
    @(posedge core_clk);
    #1;
  endtask : send_pkt
  initial begin
    void'($urandom(61500));
    repeat (16) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    samples_checked++;
    if (rec_valid !== 1'b0 || rec_count !== 32'h0) flag("reset state");
    hold = 1'b1;
    fork
      begin
        repeat (100) @(posedge core_clk);
        #1;
        hold = 1'b0;
      end
    join_none
    send_pkt(8'h09, 160, 0);
    for (int i = 0; i < 14; i++) send_pkt(codes[i % 7], (i < 2) ? 1 + 3 * i : 1 + $urandom % 40, 0);
    send_pkt(8'h05, 40, 3);
    for (int n = 0; n < 3000 && expq.size() != 0; n++) @(posedge core_clk);
    repeat (4) @(posedge core_clk);
    #1;
    samples_checked++;
    if (expq.size() != 0 || rec_count !== 32'(npkt)) flag("record total");
    end_of_test();
  end
endmodule : testbench
